// ### logic/lcer_pkg.sv
/*
  Shared constants for the lane crossbar and elastic release block.
  Assumes a single 100 MHz clock and quad-octet lane words.
*/
package lcer_pkg;
  // ---------------------------------------------------------------
  // Lane and word geometry
  // ---------------------------------------------------------------
  localparam int NUM_PHY = 2;
  localparam int NUM_LOG = 16;
  localparam int SEL_W = 4;
  localparam int WORD_W = 32;
  localparam int ARR_W = 6;
  localparam int PERIOD_W = 6;
  localparam int DEPTH_W = 4;
  localparam int EB_DEPTH_FULL = 16;
  localparam int EB_DEPTH_HALF = 8;
  localparam logic [8:0] KF_HALF_DEPTH = 9'h020;
  localparam logic [ARR_W-1:0] ARR_ONE = 6'h01;

  // ---------------------------------------------------------------
  // Serdes PLL codes for 64b/66b modes
  // ---------------------------------------------------------------
  localparam logic [7:0] MPY_CODE_66 = 8'h21;
  // Multiplier in quarter steps: 8.25 = 33/4
  localparam logic [7:0] MPY_QUARTERS_66 = 8'h21;
  localparam logic [7:0] MPY_QUARTERS_BAD = 8'h00;
  localparam logic [1:0] RATE_CODE_X4 = 2'h0;
  localparam logic [1:0] RATE_CODE_X2 = 2'h1;
  localparam logic [2:0] RATE_FACTOR_X4 = 3'h4;
  localparam logic [2:0] RATE_FACTOR_X2 = 3'h2;
  localparam logic [2:0] RATE_FACTOR_BAD = 3'h0;

  // ---------------------------------------------------------------
  // Release state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCER_IDLE = 2'b00,
    LCER_WAIT = 2'b01,
    LCER_RUN = 2'b10
  } lcer_rel_e;
endpackage

// ### logic/lcer_top.sv
/*
  Receive lane crossbar, lane arrival measurement, multiframe counter
  and elastic buffer release for a subclass-1 link receiver.
  Assumes lane words arrive on clk_i already deserialised; the link
  clock and sysref pins are asynchronous and are synchronised here.
*/
// What this block does
// - Multiplier code 0x21 gives 8.25; divide by N
// - Rate code 0x1 factor 2, 0x0 factor 4
// - Crossbar maps any physical pair to logical lane
// - Captured sysref resets the multiframe counter
// - Device receives; logic device transmits lanes
// - Each lane writes into an elastic buffer
// - Release shifted by delay; zero at edge
// - Release once per period, after all lanes arrive
// - Delay chosen for transmitter/receiver phase relation
// - Sysref timing and release point fixed each startup
// - Arrival measured against modulo-64 sysref-aligned counter
// - Buffer depth 16, or 8 when K*F is 32
// - Subclass 0: self counter, release after latest lane
`timescale 1ns/1ps
module lcer_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins: clock, sysref, lane word valid and data per pair
  input wire logic link_clk_i,
  input wire logic sysref_i,
  input wire logic [lcer_pkg::NUM_PHY-1:0] serdes_receive_pair_vld_i,
  input wire logic [lcer_pkg::NUM_PHY*lcer_pkg::WORD_W-1:0]
    serdes_receive_pair_data_i,
  // Configuration
  input wire logic [lcer_pkg::NUM_PHY*lcer_pkg::SEL_W-1:0] lane_sel_i,
  input wire logic [lcer_pkg::NUM_PHY-1:0] lane_en_i,
  input wire logic subclass1_i,
  input wire logic [8:0] k_times_f_i,
  input wire logic [lcer_pkg::PERIOD_W-1:0] mf_period_m1_i,
  input wire logic [lcer_pkg::ARR_W-1:0] release_buffer_delay_i,
  input wire logic [7:0] pll_reference_divider_i,
  input wire logic [7:0] pll_multiplier_code_i,
  input wire logic [1:0] serdes_rate_code_i,
  // Derived serdes settings
  output logic [7:0] pll_ref_divide_o,
  output logic [7:0] pll_mult_quarters_o,
  output logic [2:0] lane_rate_factor_o,
  // Status
  output logic [lcer_pkg::NUM_PHY*lcer_pkg::ARR_W-1:0] lane_arrival_time_o,
  output logic [lcer_pkg::PERIOD_W-1:0] mf_count_o,
  output logic mf_edge_o,
  output logic released_o,
  output logic eb_overflow_o,
  // Released data, indexed by logical lane
  output logic [lcer_pkg::NUM_LOG-1:0] log_vld_o,
  output logic [lcer_pkg::NUM_LOG*lcer_pkg::WORD_W-1:0] log_data_o
);
  localparam int NP = lcer_pkg::NUM_PHY;
  localparam int W = lcer_pkg::WORD_W;
  localparam int DW = lcer_pkg::DEPTH_W;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] lclk_s;
  logic [2:0] sref_s;
  logic [NP-1:0] vld_m;
  logic [NP-1:0] vld_s;
  logic [NP*W-1:0] dat_m;
  logic [NP*W-1:0] dat_s;
  logic word_tick;
  logic sysref_evt;

  // Two flops before use; third stage only for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lclk_s <= 3'h0;
      sref_s <= 3'h0;
      vld_m <= '0;
      vld_s <= '0;
      dat_m <= '0;
      dat_s <= '0;
    end else begin
      lclk_s <= {lclk_s[1:0], link_clk_i};
      sref_s <= {sref_s[1:0], sysref_i};
      vld_m <= serdes_receive_pair_vld_i;
      vld_s <= vld_m;
      dat_m <= serdes_receive_pair_data_i;
      dat_s <= dat_m;
    end
  end

  // Word rate enable from link clock rising edge
  assign word_tick = lclk_s[1] & ~lclk_s[2];
  // Only honoured in subclass 1; subclass 0 ignores the pin
  assign sysref_evt = sref_s[1] & ~sref_s[2] & subclass1_i;

  // ---------------------------------------------------------------
  // Serdes PLL code decode
  // ---------------------------------------------------------------
  // Divider passes through as divide-by-N; unknown codes give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_ref_divide_o <= 8'h00;
      pll_mult_quarters_o <= lcer_pkg::MPY_QUARTERS_BAD;
      lane_rate_factor_o <= lcer_pkg::RATE_FACTOR_BAD;
    end else begin
      pll_ref_divide_o <= pll_reference_divider_i;
      if (pll_multiplier_code_i == lcer_pkg::MPY_CODE_66) begin
        pll_mult_quarters_o <= lcer_pkg::MPY_QUARTERS_66;
      end else begin
        pll_mult_quarters_o <= lcer_pkg::MPY_QUARTERS_BAD;
      end
      case (serdes_rate_code_i)
        lcer_pkg::RATE_CODE_X2: lane_rate_factor_o <= lcer_pkg::RATE_FACTOR_X2;
        lcer_pkg::RATE_CODE_X4: lane_rate_factor_o <= lcer_pkg::RATE_FACTOR_X4;
        default: lane_rate_factor_o <= lcer_pkg::RATE_FACTOR_BAD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Multiframe counter and arrival reference
  // ---------------------------------------------------------------
  logic [lcer_pkg::PERIOD_W-1:0] mf_cnt;
  logic [lcer_pkg::ARR_W-1:0] arr_ref;
  logic [lcer_pkg::PERIOD_W-1:0] rel_pt;
  logic [6:0] rel_sum;
  logic rel_hit;

  // Sysref realigns; without it the counter free-runs (subclass 0)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf_cnt <= '0;
      arr_ref <= '0;
    end else if (sysref_evt) begin
      mf_cnt <= '0;
      arr_ref <= '0;
    end else if (word_tick) begin
      arr_ref <= arr_ref + lcer_pkg::ARR_ONE;
      if (mf_cnt >= mf_period_m1_i) begin
        mf_cnt <= '0;
      end else begin
        mf_cnt <= mf_cnt + 6'h01;
      end
    end
  end

  // Delay wraps around the period instead of saturating
  assign rel_sum = {1'b0, release_buffer_delay_i} % ({1'b0, mf_period_m1_i}
                   + 7'h01);
  assign rel_pt = rel_sum[lcer_pkg::PERIOD_W-1:0];
  // Zero delay hits exactly at the counter edge
  assign rel_hit = word_tick && (mf_cnt == rel_pt);

  // ---------------------------------------------------------------
  // Per-lane elastic buffers and arrival capture
  // ---------------------------------------------------------------
  logic [DW-1:0] depth_m1;
  logic [W-1:0] eb_mem [NP][lcer_pkg::EB_DEPTH_FULL];
  logic [DW-1:0] wr_ptr [NP];
  logic [DW-1:0] rd_ptr [NP];
  logic [DW:0] fill [NP];
  logic [NP-1:0] arrived;
  logic [NP-1:0] ovf;
  logic all_arrived;
  logic last_arrival;
  logic rel_now;
  logic rd_go;
  lcer_pkg::lcer_rel_e rel_st;

  // Shallower buffer when K*F is 32
  assign depth_m1 = (k_times_f_i == lcer_pkg::KF_HALF_DEPTH) ?
    DW'(lcer_pkg::EB_DEPTH_HALF - 1) :
    DW'(lcer_pkg::EB_DEPTH_FULL - 1);
  assign all_arrived = &(arrived | ~lane_en_i);
  // Subclass 0 releases on the tick after the last lane begins
  assign last_arrival = all_arrived && (|lane_en_i);
  // Release decision. Reading starts on this very tick: at the largest
  // usable delay the oldest word is read as it is overwritten, which
  // must not count as an overflow. Reading a tick later would lose it.
  assign rel_now = (rel_st == lcer_pkg::LCER_WAIT) &&
    (subclass1_i ? (rel_hit && all_arrived) :
      (word_tick && last_arrival));
  // One read strobe shared by all lanes keeps them in step
  assign rd_go = word_tick && ((rel_st == lcer_pkg::LCER_RUN) || rel_now);

  for (genvar p = 0; p < NP; p++) begin : g_lane
    logic wr;
    logic rd;
    assign wr = word_tick && vld_s[p] && lane_en_i[p];
    assign rd = rd_go && lane_en_i[p];

    // Buffer write absorbs lane-to-lane skew
    always_ff @(posedge clk_i) begin
      if (wr) begin
        eb_mem[p][wr_ptr[p]] <= dat_s[p*W +: W];
      end
    end

    // Pointers wrap at the selected depth
    always_ff @(posedge clk_i) begin
      if (rst_i || sysref_evt) begin
        wr_ptr[p] <= '0;
        rd_ptr[p] <= '0;
        fill[p] <= '0;
        arrived[p] <= 1'b0;
        ovf[p] <= 1'b0;
        lane_arrival_time_o[p*lcer_pkg::ARR_W +: lcer_pkg::ARR_W] <= '0;
      end else begin
        if (wr) begin
          wr_ptr[p] <= (wr_ptr[p] == depth_m1) ? '0 : wr_ptr[p] + 4'h1;
        end
        if (rd) begin
          rd_ptr[p] <= (rd_ptr[p] == depth_m1) ? '0 : rd_ptr[p] + 4'h1;
        end
        // Fill stops at the depth; the sticky flag records any loss
        if (wr && !rd && fill[p] <= {1'b0, depth_m1}) begin
          fill[p] <= fill[p] + 5'h01;
        end else if (rd && !wr && fill[p] != '0) begin
          fill[p] <= fill[p] - 5'h01;
        end
        // Write into a full buffer while read stands still loses data
        if (wr && !rd && fill[p] > {1'b0, depth_m1}) begin
          ovf[p] <= 1'b1;
        end
        if (wr && !arrived[p]) begin
          arrived[p] <= 1'b1;
          lane_arrival_time_o[p*lcer_pkg::ARR_W +: lcer_pkg::ARR_W] <=
            arr_ref;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Release sequencing
  // ---------------------------------------------------------------
  // Opportunity every period in subclass 1, every tick in subclass 0; taken only once every lane has data
  always_ff @(posedge clk_i) begin
    if (rst_i || sysref_evt) begin
      rel_st <= lcer_pkg::LCER_IDLE;
    end else begin
      case (rel_st)
        lcer_pkg::LCER_IDLE: begin
          if (|lane_en_i) begin
            rel_st <= lcer_pkg::LCER_WAIT;
          end
        end
        lcer_pkg::LCER_WAIT: begin
          // Same decision that already started the first read
          if (rel_now) begin
            rel_st <= lcer_pkg::LCER_RUN;
          end
        end
        lcer_pkg::LCER_RUN: rel_st <= lcer_pkg::LCER_RUN;
        default: rel_st <= lcer_pkg::LCER_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Crossbar and registered outputs
  // ---------------------------------------------------------------
  // Any physical pair can feed any logical lane; a later pair wins
  // when two select the same lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      log_vld_o <= '0;
      log_data_o <= '0;
    end else begin
      log_vld_o <= '0;
      for (int p = 0; p < NP; p++) begin
        // First word goes out on the release tick itself
        if (rd_go && lane_en_i[p]) begin
          log_vld_o[lane_sel_i[p*lcer_pkg::SEL_W +: lcer_pkg::SEL_W]]
            <= 1'b1;
          log_data_o[lane_sel_i[p*lcer_pkg::SEL_W +: lcer_pkg::SEL_W]*W +: W]
            <= eb_mem[p][rd_ptr[p]];
        end
      end
    end
  end

  // Status flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mf_count_o <= '0;
      mf_edge_o <= 1'b0;
      released_o <= 1'b0;
      eb_overflow_o <= 1'b0;
    end else begin
      mf_count_o <= mf_cnt;
      mf_edge_o <= word_tick && (mf_cnt == '0);
      // Raised with the first released word, so status and data agree
      released_o <= (rel_st == lcer_pkg::LCER_RUN) || rel_now;
      eb_overflow_o <= |ovf;
    end
  end
endmodule

// ### verif/lcer_sva.sv
/*
  Checker for the lane crossbar and elastic release top.
  Assumes it is bound to lcer_top and sees the clk_i domain only.
*/
`timescale 1ns/1ps
module lcer_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic sysref_i,
  input wire logic [7:0] pll_reference_divider_i,
  input wire logic [7:0] pll_multiplier_code_i,
  input wire logic [1:0] serdes_rate_code_i,
  input wire logic [7:0] pll_ref_divide_o,
  input wire logic [7:0] pll_mult_quarters_o,
  input wire logic [2:0] lane_rate_factor_o,
  input wire logic [lcer_pkg::PERIOD_W-1:0] mf_count_o,
  input wire logic mf_edge_o,
  input wire logic released_o,
  input wire logic [lcer_pkg::NUM_LOG-1:0] log_vld_o
);
  // Single domain, so one clocking and one disable
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  mult_ok_a: assert property (
    pll_multiplier_code_i == 8'h21 |=> pll_mult_quarters_o == 8'h21)
    else $error("multiplier 0x21 not decoded");
  mult_bad_a: assert property (
    pll_multiplier_code_i != 8'h21 |=> pll_mult_quarters_o == 8'h00)
    else $error("unknown multiplier decoded");
  pll_reference_divider_a: assert property (
    1'b1 |=> pll_ref_divide_o == $past(pll_reference_divider_i))
    else $error("divider not followed");
  rate_x2_a: assert property (
    serdes_rate_code_i == 2'h1 |=> lane_rate_factor_o == 3'h2)
    else $error("rate code 1 wrong");
  rate_x4_a: assert property (
    serdes_rate_code_i == 2'h0 |=> lane_rate_factor_o == 3'h4)
    else $error("rate code 0 wrong");
  edge_pulse_a: assert property (
    mf_edge_o |=> !mf_edge_o)
    else $error("period edge too long");
  vld_released_a: assert property (
    |log_vld_o |-> released_o)
    else $error("data before release");
  vld_pulse_a: assert property (
    |log_vld_o |=> log_vld_o == '0)
    else $error("lane valid too long");
  rel_hold_a: assert property (
    (!sysref_i)[*6] ##0 released_o |=> released_o)
    else $error("release dropped");
  mf_step_a: assert property (
    mf_count_o != $past(mf_count_o) |->
      mf_count_o == 6'h00 || mf_count_o == $past(mf_count_o) + 6'h01)
    else $error("counter skipped");
endmodule

bind lcer_top lcer_sva lcer_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .sysref_i(sysref_i),
  .pll_reference_divider_i(pll_reference_divider_i),
  .pll_multiplier_code_i(pll_multiplier_code_i),
  .serdes_rate_code_i(serdes_rate_code_i),
  .pll_ref_divide_o(pll_ref_divide_o),
  .pll_mult_quarters_o(pll_mult_quarters_o),
  .lane_rate_factor_o(lane_rate_factor_o), .mf_count_o(mf_count_o),
  .mf_edge_o(mf_edge_o), .released_o(released_o), .log_vld_o(log_vld_o)
);

// ### verif/lcer_tx_model.sv
/*
  Transmitter model driving the lane pins of the receiver.
  Assumes the bench raises run_i once the receiver is configured.
*/
`timescale 1ns/1ps
module lcer_tx_model (
  // Control from the bench
  input wire logic run_i,
  input wire logic [1:0] lane_on_i,
  // Lane pins toward the receiver
  output logic link_clk_o,
  output logic [1:0] vld_o,
  output logic [63:0] data_o
);
  int n;
  // One word per link clock; the clock stands still while run_i is low
  initial begin
    link_clk_o = 1'b0;
    vld_o = 2'h0;
    data_o = 64'h0;
    n = 0;
    forever begin
      for (int p = 0; p < 2; p++) begin
        vld_o[p] = run_i && lane_on_i[p];
        // Idle lines toggle, so a stale word never looks fresh
        data_o[p*32+:32] = vld_o[p] ? {8'(p + 1), 24'(n)}
                                    : ~data_o[p*32+:32];
      end
      n++;
      #62.5 link_clk_o = run_i;
      #62.5 link_clk_o = 1'b0;
    end
  end
endmodule

// ### verif/lcer_top_tb.sv
/*
  Self-checking bench for lcer_top fed by the transmitter model.
  Assumes lcer_pkg, lcer_top, lcer_tx_model and lcer_sva are compiled.
*/
`timescale 1ns/1ps
module lcer_top_tb;
  typedef struct {
    logic [7:0] div;
    logic [7:0] pll_multiplier_code;
    logic [1:0] rate;
    logic [7:0] q;
    logic [2:0] f;
  } lcer_row_s;
  // Decode rows: codes beside the settings they should give
  lcer_row_s rows [4] = '{'{8'h20, 8'h21, 2'h1, 8'h21, 3'h2},
    '{8'h30, 8'h21, 2'h0, 8'h21, 3'h4}, '{8'h05, 8'h20, 2'h2, 8'h00, 3'h0},
    '{8'h0c, 8'h14, 2'h3, 8'h00, 3'h0}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sysref_i = 1'b0;
  logic sub1 = 1'b1;
  // Pair 0 carries lane 9, pair 1 lane 2
  logic [7:0] lane_sel = 8'h29;
  // Delay past the period end, so it must wrap
  logic [5:0] release_buffer_delay = 6'h13;
  logic [7:0] div = 8'h00;
  logic [7:0] pll_multiplier_code = 8'h00;
  logic [1:0] rate = 2'h0;
  logic run = 1'b0;
  logic [1:0] lane_on = 2'h0;
  // Buffer depth select: 16 words unless K*F is 32
  logic [8:0] kf = 9'h010;
  logic link_clk;
  logic [1:0] vld;
  logic [63:0] data;
  logic [7:0] d_o;
  logic [7:0] q_o;
  logic [2:0] f_o;
  logic [5:0] cnt_o;
  logic rel_o;
  logic [15:0] lvld;
  logic [511:0] ldata;
  logic [11:0] arr;
  logic ovf_o;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  lcer_tx_model lcer_tx_model_inst (
    .run_i(run), .lane_on_i(lane_on), .link_clk_o(link_clk),
    .vld_o(vld), .data_o(data));
  lcer_top lcer_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
    .sysref_i(sysref_i), .serdes_receive_pair_vld_i(vld),
    .serdes_receive_pair_data_i(data), .lane_sel_i(lane_sel),
    .lane_en_i(2'h3), .subclass1_i(sub1), .k_times_f_i(kf),
    .mf_period_m1_i(6'h0f), .release_buffer_delay_i(release_buffer_delay),
    .pll_reference_divider_i(div), .pll_multiplier_code_i(pll_multiplier_code),
    .serdes_rate_code_i(rate), .pll_ref_divide_o(d_o),
    .pll_mult_quarters_o(q_o), .lane_rate_factor_o(f_o),
    .lane_arrival_time_o(arr), .mf_count_o(cnt_o), .mf_edge_o(),
    .released_o(rel_o), .eb_overflow_o(ovf_o), .log_vld_o(lvld),
    .log_data_o(ldata));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [63:0] e,
                       input logic [63:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic pulse_sysref();
    sysref_i = 1'b1;
    repeat (4) @(negedge clk_i);
    sysref_i = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  // Bounded wait for release, then the counter it happened at
  task automatic rel_check();
    for (int i = 0; i < 3000 && rel_o !== 1'b1; i++) @(negedge clk_i);
    check("released", 1'b1, rel_o);
    check("release_count", 6'(release_buffer_delay % 6'h10), cnt_o);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    check("reset_release", 1'b0, rel_o);
    check("reset_valid", 16'h0, lvld);
    rst_i = 1'b0;
    foreach (rows[r]) begin
      div = rows[r].div;
      pll_multiplier_code = rows[r].pll_multiplier_code;
      rate = rows[r].rate;
      @(negedge clk_i);
      check("divider", rows[r].div, d_o);
      check("multiplier", rows[r].q, q_o);
      check("rate_factor", rows[r].f, f_o);
    end
    // One lane missing: no release however many periods pass
    pulse_sysref();
    lane_on = 2'h1;
    run = 1'b1;
    repeat (500) @(negedge clk_i);
    check("one_lane_release", 1'b0, rel_o);
    check("overflow_lone", 1'b1, ovf_o);
    lane_on = 2'h3;
    rel_check();
    for (int i = 0; i < 300 && lvld === 16'h0; i++) @(negedge clk_i);
    check("lane_map", 16'h0204, lvld);
    check("lane9_word", 8'h01, ldata[9*32+24+:8]);
    check("lane2_word", 8'h02, ldata[2*32+24+:8]);
    // Second lane started 500 cycles, so 40 words, after the first
    check("arrival_gap", 6'h28, 6'(arr[11:6] - arr[5:0]));
    // Sysref restarts the reference; zero delay releases at the edge
    pulse_sysref();
    check("sysref_clear", 1'b0, rel_o);
    check("overflow_clear", 1'b0, ovf_o);
    release_buffer_delay = 6'h00;
    rel_check();
    // Delay 0 is the latest usable point here: read meets overwrite
    check("overflow_edge", 1'b0, ovf_o);
    // K*F of 32 halves the buffer, so 16 words of wait overflow it
    kf = 9'h020;
    pulse_sysref();
    rel_check();
    check("overflow_half", 1'b1, ovf_o);
    // Subclass 0: self release, stray sysref ignored
    run = 1'b0;
    rst_i = 1'b1;
    sub1 = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    run = 1'b1;
    for (int i = 0; i < 3000 && rel_o !== 1'b1; i++) @(negedge clk_i);
    check("self_release", 1'b1, rel_o);
    pulse_sysref();
    check("sysref_ignored", 1'b1, rel_o);
    conclude();
  end
endmodule
